/* File: shared/rpm_cfg.svh */
`ifndef RPM_CFG_SVH
`define RPM_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define RPM_CLK_PERIOD_NS  25
`define RPM_TICK_NS        10000000
`define RPM_TICK_CYCLES    (`RPM_TICK_NS / `RPM_CLK_PERIOD_NS)
`define RPM_TICKS_PER_DS   17'd10
`define RPM_PFM_PHASE_FULL 29'h0BB80000
`define RPM_PFM_ON_FULL    13'h0BB8

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RPM_OFS_CTRL     6'h00
`define RPM_OFS_PERIOD   6'h04
`define RPM_OFS_MIN_ON   6'h08
`define RPM_OFS_RATE     6'h0C
`define RPM_OFS_ASSIGN   6'h10
`define RPM_OFS_ATTRIB   6'h14
`define RPM_OFS_CLASS    6'h18
`define RPM_OFS_STATUS   6'h1C
`define RPM_OFS_MASK     6'h20

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define RPM_CTRL_FUNC    1:0
`define RPM_CTRL_PFM     2
`define RPM_CTRL_PART    4:3
`define RPM_CTRL_DSRC    7:5
`define RPM_CTRL_ASRC    10:8

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define RPM_STS_PULSE    0
`define RPM_STS_RLY_ERR  1
`define RPM_STS_ALM_ERR  2
`define RPM_STS_REJECT   3

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define RPM_CTRL_RST       11'h000
`define RPM_PERIOD_RST     14'h0064
`define RPM_PERIOD_MAX     14'h2706
`define RPM_MIN_ON_RST     14'h0003
`define RPM_MIN_ON_MIN     14'h0003
`define RPM_RATE_RST       8'h3C
`define RPM_RATE_MIN       8'h01
`define RPM_RATE_MAX       8'hB4

`endif

/* File: shared/rpm_pkg.sv */
package rpm_pkg;

  typedef enum logic [1:0] {
    RPM_FN_OFF,
    RPM_FN_CTRL,
    RPM_FN_DIAG
  } rpm_func_e;

  typedef enum logic [1:0] {
    RPM_PART_NONE,
    RPM_PART_NEG,
    RPM_PART_POS
  } rpm_part_e;

  typedef enum logic [2:0] {
    RPM_SRC_ASSIGNED,
    RPM_SRC_CLS_M,
    RPM_SRC_CLS_S,
    RPM_SRC_CLS_C,
    RPM_SRC_CLS_F
  } rpm_dsrc_e;

  typedef enum logic [1:0] {
    RPM_ST_IDLE,
    RPM_ST_PWM,
    RPM_ST_PFM_OFF,
    RPM_ST_PFM_ON
  } rpm_state_e;

endpackage

/* File: hdl/rpm_tick.sv */
`timescale 1ns/1ps

module rpm_tick #(
  parameter int unsigned TICK_CYCLES = 400000
) (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  output logic      tick_o
);

  localparam int unsigned CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  logic [CW-1:0] cnt_q;

  // Free running divider; one pulse per tick period.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q == CW'(TICK_CYCLES - 1)) begin
      cnt_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + CW'(1);
      tick_o <= 1'b0;
    end
  end

endmodule // rpm_tick

/* File: hdl/rpm_top.sv */
`timescale 1ns/1ps
`include "rpm_cfg.svh"

// How it works
// - Controller mode: relay energized for pulse_on_time, then off for pulse_off_interval.
// - Pulse-width mode keeps the period fixed and varies only the on share.
// - Pulse-frequency mode uses fixed-length pulses and varies only the gap.
// - At maximum pulse rate the gap equals the pulse length.
// - Drive part selects none, negative or positive manipulated value; default none.
// - Pulse-width period runs from shortest on time to 999.0 s, default 10.0 s.
// - Period is never below shortest on time; violating writes are refused.
// - Pulse-width pulses shorter than shortest on time (0.3 s up, default 0.3 s) are dropped.
// - Pulse-frequency rate limit is 1 to 180 per minute, default 60.
// - Pulse length follows from the configured maximum pulse rate.
// - Diagnostics relay is fail-safe: energized without error, released on error.
// - The alarm relay is always fail-safe.
// - Diagnostics source is assigned messages (default) or one of four classes.
// - With a class selected, any active message of that class releases the relay.
// - The list of messages attributed to the relays is shown read only.

module rpm_top #(
  parameter int unsigned TICK_CYCLES = `RPM_TICK_CYCLES
) (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [15:0] mv_i,
  input  wire logic [15:0] msg_active_i,
  output logic             relay_o,
  output logic             alarm_relay_o,
  output logic             irq_o
);
  import rpm_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [10:0] ctrl_q;
  logic [13:0] period_q;
  logic [13:0] min_on_q;
  logic [7:0]  rate_q;
  logic [31:0] assign_q;
  logic [31:0] class_q;
  logic [3:0]  sts_q;
  logic [3:0]  mask_q;
  logic        tick;
  logic        acc_wr;
  logic        acc_rd;
  logic [31:0] wdata;
  logic [3:0]  sts_set;
  logic        reject;

  rpm_func_e   func;
  rpm_part_e   part;
  rpm_dsrc_e   dsrc;
  rpm_dsrc_e   asrc;
  logic        pfm_sel;

  assign func    = rpm_func_e'(ctrl_q[`RPM_CTRL_FUNC]);
  assign part    = rpm_part_e'(ctrl_q[`RPM_CTRL_PART]);
  assign dsrc    = rpm_dsrc_e'(ctrl_q[`RPM_CTRL_DSRC]);
  assign asrc    = rpm_dsrc_e'(ctrl_q[`RPM_CTRL_ASRC]);
  assign pfm_sel = ctrl_q[`RPM_CTRL_PFM];

  rpm_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .tick_o     (tick)
  );

  // ----------------------------------------
  // Avalon slave handshake
  // ----------------------------------------
  // Every access waits exactly one cycle, so read data can come from a flop.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  assign acc_wr = avs_write_i && !avs_waitrequest_o;
  assign acc_rd = avs_read_i && avs_waitrequest_o;

  // Byte enables select which lanes of the old value are replaced.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  logic [31:0] cur_val;
  always_comb begin
    case (avs_address_i)
      `RPM_OFS_CTRL:   cur_val = {21'h000000, ctrl_q};
      `RPM_OFS_PERIOD: cur_val = {18'h00000, period_q};
      `RPM_OFS_MIN_ON: cur_val = {18'h00000, min_on_q};
      `RPM_OFS_RATE:   cur_val = {24'h000000, rate_q};
      `RPM_OFS_ASSIGN: cur_val = assign_q;
      `RPM_OFS_CLASS:  cur_val = class_q;
      `RPM_OFS_MASK:   cur_val = {28'h0000000, mask_q};
      default:         cur_val = 32'h00000000;
    endcase
  end

  assign wdata = merge(cur_val, avs_writedata_i, avs_byteenable_i);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Limits are checked on the merged value; a refused write keeps the
  // old setting so period and shortest on time stay consistent.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q   <= `RPM_CTRL_RST;
      period_q <= `RPM_PERIOD_RST;
      min_on_q <= `RPM_MIN_ON_RST;
      rate_q   <= `RPM_RATE_RST;
      assign_q <= 32'h00000000;
      class_q  <= 32'h00000000;
      mask_q   <= 4'h0;
      reject   <= 1'b0;
    end else begin
      reject <= 1'b0;
      if (acc_wr) begin
        case (avs_address_i)
          `RPM_OFS_CTRL: ctrl_q <= wdata[10:0];
          `RPM_OFS_PERIOD: begin
            if (wdata[13:0] >= min_on_q && wdata[13:0] <= `RPM_PERIOD_MAX) begin
              period_q <= wdata[13:0];
            end else begin
              reject <= 1'b1;
            end
          end
          `RPM_OFS_MIN_ON: begin
            if (wdata[13:0] >= `RPM_MIN_ON_MIN && wdata[13:0] <= period_q) begin
              min_on_q <= wdata[13:0];
            end else begin
              reject <= 1'b1;
            end
          end
          `RPM_OFS_RATE: begin
            if (wdata[7:0] >= `RPM_RATE_MIN && wdata[7:0] <= `RPM_RATE_MAX) begin
              rate_q <= wdata[7:0];
            end else begin
              reject <= 1'b1;
            end
          end
          `RPM_OFS_ASSIGN: assign_q <= wdata;
          `RPM_OFS_CLASS:  class_q  <= wdata;
          `RPM_OFS_MASK:   mask_q   <= wdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Selected share of the manipulated value
  // ----------------------------------------
  // The most negative input saturates so its magnitude still fits 15 bits.
  logic [14:0] share;
  always_comb begin
    share = 15'h0000;
    case (part)
      RPM_PART_POS: if (!mv_i[15]) share = mv_i[14:0];
      RPM_PART_NEG: begin
        if (mv_i == 16'h8000) share = 15'h7FFF;
        else if (mv_i[15]) share = 15'(-mv_i);
      end
      default: share = 15'h0000;
    endcase
  end

  // ----------------------------------------
  // Pulse-width arithmetic
  // ----------------------------------------
  logic [16:0] period_tk;
  logic [16:0] min_tk;
  logic [31:0] on_prod;
  logic [16:0] on_calc;

  assign period_tk = {3'b000, period_q} * `RPM_TICKS_PER_DS;
  assign min_tk    = {3'b000, min_on_q} * `RPM_TICKS_PER_DS;
  assign on_prod   = 32'(period_tk) * 32'(share);
  // Too short a pulse is dropped entirely to spare the actuator.
  assign on_calc   = (on_prod[31:15] < min_tk) ? 17'h00000 : on_prod[31:15];

  // ----------------------------------------
  // Pulse-frequency arithmetic
  // ----------------------------------------
  logic [28:0] acc_q;
  logic [12:0] on_acc_q;
  logic [22:0] pfm_inc;
  logic [28:0] acc_sum;
  logic [12:0] on_sum;

  assign pfm_inc = 23'(32'(share) * 32'(rate_q));
  assign acc_sum = acc_q + 29'(pfm_inc);
  assign on_sum  = on_acc_q + 13'(rate_q);

  // ----------------------------------------
  // Modulator
  // ----------------------------------------
  rpm_state_e  state_q;
  logic [16:0] pos_q;
  logic [16:0] on_q;
  logic        pulse_evt;

  // A change of function or mode drops back to idle and restarts cleanly.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q   <= RPM_ST_IDLE;
      pos_q     <= 17'h00000;
      on_q      <= 17'h00000;
      acc_q     <= 29'h00000000;
      on_acc_q  <= 13'h0000;
      pulse_evt <= 1'b0;
    end else begin
      pulse_evt <= 1'b0;
      case (state_q)
        RPM_ST_IDLE: begin
          pos_q    <= 17'h00000;
          on_q     <= on_calc;
          acc_q    <= 29'h00000000;
          on_acc_q <= 13'h0000;
          if (func == RPM_FN_CTRL) begin
            state_q <= pfm_sel ? RPM_ST_PFM_OFF : RPM_ST_PWM;
          end
        end
        RPM_ST_PWM: begin
          if (func != RPM_FN_CTRL || pfm_sel) begin
            state_q <= RPM_ST_IDLE;
          end else if (tick) begin
            if (pos_q + 17'h00001 >= period_tk) begin
              pos_q     <= 17'h00000;
              on_q      <= on_calc;
              pulse_evt <= (on_calc != 17'h00000);
            end else begin
              pos_q <= pos_q + 17'h00001;
            end
          end
        end
        RPM_ST_PFM_OFF: begin
          if (func != RPM_FN_CTRL || !pfm_sel) begin
            state_q <= RPM_ST_IDLE;
          end else if (tick) begin
            if (acc_sum >= `RPM_PFM_PHASE_FULL) begin
              acc_q     <= acc_sum - `RPM_PFM_PHASE_FULL;
              on_acc_q  <= 13'h0000;
              pulse_evt <= 1'b1;
              state_q   <= RPM_ST_PFM_ON;
            end else begin
              acc_q <= acc_sum;
            end
          end
        end
        RPM_ST_PFM_ON: begin
          // Phase keeps running during the pulse, so at full share the gap
          // ends up as long as the pulse itself.
          if (func != RPM_FN_CTRL || !pfm_sel) begin
            state_q <= RPM_ST_IDLE;
          end else if (tick) begin
            acc_q    <= acc_sum;
            on_acc_q <= on_sum;
            if (on_sum >= `RPM_PFM_ON_FULL) begin
              state_q <= RPM_ST_PFM_OFF;
            end
          end
        end
        default: state_q <= RPM_ST_IDLE;
      endcase
    end
  end

  logic ctrl_drive;
  always_comb begin
    case (state_q)
      RPM_ST_PWM:    ctrl_drive = (pos_q < on_q);
      RPM_ST_PFM_ON: ctrl_drive = 1'b1;
      default:       ctrl_drive = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Diagnostic message matching
  // ----------------------------------------
  // Class codes per message: 0 M, 1 S, 2 C, 3 F.
  logic [15:0] rly_hit;
  logic [15:0] alm_hit;
  logic [1:0]  rly_cls;
  logic [1:0]  alm_cls;
  logic        rly_by_cls;
  logic        alm_by_cls;

  assign rly_by_cls = (dsrc >= RPM_SRC_CLS_M) && (dsrc <= RPM_SRC_CLS_F);
  assign alm_by_cls = (asrc >= RPM_SRC_CLS_M) && (asrc <= RPM_SRC_CLS_F);
  assign rly_cls    = 2'(ctrl_q[`RPM_CTRL_DSRC] - 3'h1);
  assign alm_cls    = 2'(ctrl_q[`RPM_CTRL_ASRC] - 3'h1);

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_msg
      assign rly_hit[gi] = msg_active_i[gi] &&
                           (rly_by_cls ? (class_q[2*gi +: 2] == rly_cls)
                                       : assign_q[gi]);
      assign alm_hit[gi] = msg_active_i[gi] &&
                           (alm_by_cls ? (class_q[2*gi +: 2] == alm_cls)
                                       : assign_q[16 + gi]);
    end
  endgenerate

  logic rly_err;
  logic alm_err;
  logic rly_err_q;
  logic alm_err_q;

  assign rly_err = |rly_hit;
  assign alm_err = |alm_hit;

  // ----------------------------------------
  // Relay outputs
  // ----------------------------------------
  // Relays start released; fail-safe ones pull in one cycle after reset.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      relay_o       <= 1'b0;
      alarm_relay_o <= 1'b0;
      rly_err_q     <= 1'b0;
      alm_err_q     <= 1'b0;
    end else begin
      case (func)
        RPM_FN_CTRL: relay_o <= ctrl_drive;
        RPM_FN_DIAG: relay_o <= !rly_err;
        default:     relay_o <= 1'b0;
      endcase
      alarm_relay_o <= !alm_err;
      rly_err_q     <= rly_err && (func == RPM_FN_DIAG);
      alm_err_q     <= alm_err;
    end
  end

  // ----------------------------------------
  // Status and interrupt
  // ----------------------------------------
  assign sts_set[`RPM_STS_PULSE]   = pulse_evt;
  assign sts_set[`RPM_STS_RLY_ERR] = rly_err && (func == RPM_FN_DIAG) && !rly_err_q;
  assign sts_set[`RPM_STS_ALM_ERR] = alm_err && !alm_err_q;
  assign sts_set[`RPM_STS_REJECT]  = reject;

  // A new event in the clearing cycle survives: set is applied after clear.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sts_q <= 4'h0;
    end else if (acc_wr && avs_address_i == `RPM_OFS_STATUS && avs_byteenable_i[0]) begin
      sts_q <= (sts_q & ~avs_writedata_i[3:0]) | sts_set;
    end else begin
      sts_q <= sts_q | sts_set;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(sts_q & mask_q);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // The attributed list is a view only; writes to its offset are dropped.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (acc_rd) begin
      case (avs_address_i)
        `RPM_OFS_ATTRIB: avs_readdata_o <= assign_q;
        `RPM_OFS_STATUS: avs_readdata_o <= {18'h00000, 2'(state_q), alm_err, rly_err,
                                            alarm_relay_o, relay_o, 4'h0, sts_q};
        default:         avs_readdata_o <= cur_val;
      endcase
    end
  end

endmodule // rpm_top

/* File: tb/rpm_top_sva.sv */
`timescale 1ns/1ps
`include "rpm_cfg.svh"

// Port-level checks on the bus handshake, the alarm relay and the interrupt.
module rpm_top_chk (
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [15:0] msg_active_i,
  input wire logic        alarm_relay_o,
  input wire logic        irq_o
);
  logic        wr_acc;
  logic        asg_wr;
  logic [31:0] asg_q;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Accepted writes, and those that land on the assignment word.
  assign wr_acc = avs_write_i && !avs_waitrequest_o;
  assign asg_wr = wr_acc && (avs_address_i == `RPM_OFS_ASSIGN);

  // Shadow of the assignment word, so the read-only view is judged from outside.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      asg_q <= 32'h0;
    end else if (asg_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_byteenable_i[i]) asg_q[8*i +: 8] <= avs_writedata_i[8*i +: 8];
      end
    end
  end

  AST_WAIT_ONE:
    assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("request not answered after one wait cycle");
  AST_WAIT_PULSE:
    assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
  AST_WAIT_IDLE:
    assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
      else $error("waitrequest low without a request");
  AST_RD_HOLD:
    assert property (!(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
      else $error("read data changed without a read");
  AST_RD_UNMAP:
    assert property (avs_read_i && avs_waitrequest_o && avs_address_i > `RPM_OFS_MASK
      |=> avs_readdata_o == 32'h0) else $error("unmapped read returned data");
  AST_ATTRIB_RO:
    assert property (avs_read_i && avs_waitrequest_o && avs_address_i == `RPM_OFS_ATTRIB
      |=> avs_readdata_o == asg_q) else $error("attributed list differs from assignment");
  AST_ALM_SAFE:
    assert property ((msg_active_i == 16'h0) [*3] |-> alarm_relay_o)
      else $error("alarm relay released with no active message");
  AST_ALM_CAUSE:
    assert property ($fell(alarm_relay_o)
      |-> ($past(msg_active_i) != 16'h0) || ($past(msg_active_i, 2) != 16'h0))
      else $error("alarm relay released without a cause");
  AST_IRQ_CLR:
    assert property ($fell(irq_o) |-> $past(wr_acc) || $past(wr_acc, 2))
      else $error("interrupt dropped without a register write");

  COV_WRITE: cover property (wr_acc);
  COV_ALM_DROP: cover property ($fell(alarm_relay_o));
  COV_IRQ: cover property ($rose(irq_o));
endmodule // rpm_top_chk

bind rpm_top rpm_top_chk i_chk (
  .core_clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .msg_active_i, .alarm_relay_o,
  .irq_o
);

/* File: tb/rpm_actuator.sv */
`timescale 1ns/1ps

// Actuator on the relay contact: counts completed pulses and times on and off spans.
module rpm_actuator (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic relay_i,
  output int        n_pulse_o,
  output int        on_len_o,
  output int        off_len_o
);
  int   run_q;
  logic prev_q;

  // Spans are whole clocks; a real coil would blur anything much shorter than a tick.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_q     <= 0;
      prev_q    <= 1'b0;
      n_pulse_o <= 0;
      on_len_o  <= 0;
      off_len_o <= 0;
    end else begin
      prev_q <= relay_i;
      run_q  <= (relay_i != prev_q) ? 1 : run_q + 1;
      if (relay_i && !prev_q) off_len_o <= run_q;
      if (!relay_i && prev_q) begin
        on_len_o  <= run_q;
        n_pulse_o <= n_pulse_o + 1;
      end
    end
  end
endmodule // rpm_actuator

/* File: tb/rpm_top_tb.sv */
`timescale 1ns/1ps
`include "rpm_cfg.svh"

module rpm_top_tb;
  import rpm_pkg::*;
  localparam int TC = 4;
  logic        clk, nrst, rd, wr, waitreq, relay, alarm, irq;
  logic [5:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0]  be;
  logic [15:0] mv, msg;
  int          n_errors = 0;
  int          checked = 0;
  int          np, on_len, off_len;
  logic [5:0]  ra [8] = '{`RPM_OFS_CTRL, `RPM_OFS_PERIOD, `RPM_OFS_MIN_ON, `RPM_OFS_RATE,
                          `RPM_OFS_ASSIGN, `RPM_OFS_CLASS, `RPM_OFS_MASK, 6'h24};
  logic [31:0] rv [8] = '{32'h0, 32'h64, 32'h3, 32'h3C, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [5:0]  wa [11] = '{`RPM_OFS_PERIOD, `RPM_OFS_PERIOD, `RPM_OFS_PERIOD, `RPM_OFS_MIN_ON,
                           `RPM_OFS_MIN_ON, `RPM_OFS_MIN_ON, `RPM_OFS_PERIOD, `RPM_OFS_RATE,
                           `RPM_OFS_RATE, `RPM_OFS_RATE, `RPM_OFS_RATE};
  logic [31:0] wv [11] = '{32'h2707, 32'h2706, 32'h2, 32'h2707, 32'h2, 32'h2706, 32'h2705,
                           32'h0, 32'hB5, 32'hB4, 32'h1};
  logic [31:0] we [11] = '{32'h64, 32'h2706, 32'h2706, 32'h3, 32'h3, 32'h2706, 32'h2706,
                           32'h3C, 32'h3C, 32'hB4, 32'h1};
  logic [1:0]  pt [6] = '{2'd2, 2'd2, 2'd1, 2'd2, 2'd1, 2'd0};
  int          rt [4] = '{180, 120, 60, 180};

  rpm_top #(.TICK_CYCLES(TC)) i_dut (.core_clk_i(clk), .nrst_i(nrst), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq), .mv_i(mv), .msg_active_i(msg),
    .relay_o(relay), .alarm_relay_o(alarm), .irq_o(irq));
  rpm_actuator i_act (.core_clk_i(clk), .nrst_i(nrst), .relay_i(relay), .n_pulse_o(np),
    .on_len_o(on_len), .off_len_o(off_len));

  // Core clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // One bus transfer; the request stands until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 64);
    if (n >= 64) begin
      n_errors++;
      final_report();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_num(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
      n_errors++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // Waits for k more completed pulses, bounded so a silent relay cannot hang the run.
  task automatic wait_pulses(input int k);
    int n0, t;
    n0 = np;
    t = 0;
    while (np < n0 + k && t < 4000) begin
      @(posedge clk);
      t++;
    end
    if (t >= 4000) begin
      chk_num("pulse_wait", 0, t);
      final_report();
    end
  endtask

  function automatic int pwm_on(int per_ds, int min_ds, int share);
    int on;
    on = (per_ds * 10 * share) / 32768;
    return (on < min_ds * 10) ? 0 : on;
  endfunction

  function automatic int pfm_on(int rate);
    return (3000 + rate - 1) / rate;
  endfunction

  function automatic logic diag_err(logic [15:0] m, logic [15:0] asg, logic [31:0] c, int s);
    logic e;
    e = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (m[i] && ((s == 0) ? asg[i] : (c[2*i +: 2] == 2'(s - 1)))) e = 1'b1;
    end
    return e;
  endfunction

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog sized well above the expected run of some seven thousand cycles.
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    final_report();
  end

  // Main sequence.
  initial begin
    int          s, e, mvv;
    logic [31:0] a, c;
    logic [15:0] m;
    s = $urandom(32'h8994);
    nrst = 1'b0;
    {rd, wr, adr, wdat, mv, msg} = '0;
    be = 4'hF;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0);
      chk_word("reset_value", rv[i], q);
    end
    chk_word("alarm_idle", 32'h1, {31'h0, alarm});
    chk_word("relay_off", 32'h0, {31'h0, relay});
    $display("test reset_values done, mismatches %0d", n_errors);
    bus(1'b1, `RPM_OFS_MASK, 32'h8);
    foreach (wa[i]) begin
      bus(1'b1, wa[i], wv[i]);
      bus(1'b0, wa[i], 32'h0);
      chk_word("limit_reg", we[i], q);
      bus(1'b0, `RPM_OFS_STATUS, 32'h0);
      chk_word("refused_flag", {31'h0, we[i] != wv[i]}, {31'h0, q[3]});
      chk_word("irq", {31'h0, we[i] != wv[i]}, {31'h0, irq});
      bus(1'b1, `RPM_OFS_STATUS, 32'h8);
    end
    a = $urandom;
    bus(1'b1, `RPM_OFS_ASSIGN, a);
    bus(1'b1, `RPM_OFS_ATTRIB, ~a);
    bus(1'b0, `RPM_OFS_ATTRIB, 32'h0);
    chk_word("attrib", a, q);
    $display("test limits done, mismatches %0d", n_errors);
    bus(1'b1, `RPM_OFS_MIN_ON, 32'h3);
    bus(1'b1, `RPM_OFS_PERIOD, 32'h5);
    for (int i = 0; i < 6; i++) begin
      s = $urandom_range(32767, 20000);
      mvv = (i == 0) ? 32767 : (i == 3) ? 16384 : s;
      mv <= (i == 2) ? 16'(-mvv) : 16'(mvv);
      bus(1'b1, `RPM_OFS_CTRL, {27'h0, pt[i], 3'b001});
      e = (i < 4) ? pwm_on(5, 3, mvv) : 0;
      if (e > 0) begin
        wait_pulses(3);
        chk_num("pwm_on", e * TC, on_len);
        chk_num("pwm_period", 50 * TC, on_len + off_len);
      end else begin
        repeat (50 * TC) @(posedge clk);
        s = np;
        repeat (100 * TC) @(posedge clk);
        chk_num("pwm_silent", s, np);
      end
    end
    $display("test pwm done, mismatches %0d", n_errors);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `RPM_OFS_RATE, rt[i]);
      mv <= (i < 3) ? 16'h7FFF : 16'h4000;
      bus(1'b1, `RPM_OFS_CTRL, 32'h15);
      wait_pulses(3);
      chk_num("pfm_on", pfm_on(rt[i]) * TC, on_len);
      if (i < 3) chk_num("pfm_gap", 1, int'(off_len >= on_len - TC && off_len <= on_len + TC));
      else chk_num("pfm_gap_long", 1, int'(off_len > on_len + TC));
    end
    bus(1'b0, `RPM_OFS_STATUS, 32'h0);
    chk_word("pulse_flag", 32'h1, {31'h0, q[0]});
    $display("test pfm done, mismatches %0d", n_errors);
    a = $urandom;
    c = $urandom;
    bus(1'b1, `RPM_OFS_ASSIGN, a);
    bus(1'b1, `RPM_OFS_CLASS, c);
    bus(1'b1, `RPM_OFS_MASK, 32'h2);
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, `RPM_OFS_CTRL, {21'h0, 3'(k), 3'(k), 5'h02});
      for (int j = 0; j < 4; j++) begin
        m = (j == 0) ? 16'h0 : 16'(1 << $urandom_range(15, 0));
        msg <= m;
        repeat (4) @(posedge clk);
        chk_word("relay", {31'h0, !diag_err(m, a[15:0], c, k)}, {31'h0, relay});
        chk_word("alarm", {31'h0, !diag_err(m, a[31:16], c, k)}, {31'h0, alarm});
      end
    end
    msg <= 16'h0;
    bus(1'b1, `RPM_OFS_CTRL, 32'h2);
    bus(1'b1, `RPM_OFS_ASSIGN, 32'h0001_0001);
    bus(1'b1, `RPM_OFS_STATUS, 32'hF);
    msg <= 16'h1;
    repeat (4) @(posedge clk);
    chk_word("irq_raise", 32'h1, {31'h0, irq});
    msg <= 16'h0;
    bus(1'b1, `RPM_OFS_STATUS, 32'h2);
    repeat (3) @(posedge clk);
    chk_word("irq_masked", 32'h0, {31'h0, irq});
    bus(1'b0, `RPM_OFS_STATUS, 32'h0);
    chk_word("status", 32'h4, {28'h0, q[3:0]});
    $display("test diagnostics done, mismatches %0d", n_errors);
    final_report();
  end
endmodule // rpm_top_tb
